// file: verilog/asd_sequencer.sv
// asd_sequencer: input conversion sequencer and output refresh controller.
// assumes converter pins arrive asynchronously; host controls are on core_clk.
`timescale 1ns/10ps
module asd_sequencer
   import asd_pkg::*;
#(
   parameter int SETTLE_NS       = 10_000,
   parameter int SETTLE_SHORT_NS = 4_000,
   parameter int TRACK_NS        = 5_000,
   parameter int TRACK_SHORT_NS  = 2_000,
   parameter int DAC_SETTLE_NS   = 2_000
) (
   input  wire logic                core_clk,
   input  wire logic                resetn,
   input  wire asd_ctrl_s           ctrl,
   input  wire logic                begin_settle,
   input  wire logic                conversion_start_enable,
   input  wire logic                result_read,
   input  wire logic                scan_len_load,
   input  wire logic [4:0]          scan_len_value,
   output asd_status_s              status,
   output logic [RESULT_W-1:0]      conversion_result_register,
   input  wire logic [CHAN_W-1:0]   scan_rd_index,
   output logic [RESULT_W-1:0]      scan_rd_data,
   input  wire asd_mem_req_s        host_mem,
   output logic [WORD_W-1:0]        host_mem_rdata,
   output logic [CHAN_W-1:0]        input_select_pins,
   output logic                     adc_track,
   output logic                     convert_command,
   input  wire logic                converter_completion_indicator,
   input  wire logic [RESULT_W-1:0] adc_data_pins,
   output logic [RESULT_W-1:0]      dac_data,
   output logic [CHAN_W-1:0]        dac_select,
   output logic                     demux_enable
);
   // =========================================================
   // derived cycle counts (least times round up)
   // =========================================================
   localparam int SETTLE_CYC   = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int SETTLE_S_CYC = (SETTLE_SHORT_NS * CLK_MHZ + 999) / 1000;
   localparam int TRACK_CYC    = (TRACK_NS * CLK_MHZ + 999) / 1000;
   localparam int TRACK_S_CYC  = (TRACK_SHORT_NS * CLK_MHZ + 999) / 1000;
   localparam int DAC_SET_CYC  = (DAC_SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int HOLD_N_CYC   = SLOT_NORM_CYC - DAC_SET_CYC - SLOT_OVERHEAD;
   localparam int HOLD_F_CYC   = SLOT_FAST_CYC - DAC_SET_CYC - SLOT_OVERHEAD;
   typedef enum logic [2:0] {
      A_IDLE   = 3'b000,
      A_SETTLE = 3'b001,
      A_TRACK  = 3'b010,
      A_HOLD   = 3'b011,
      A_CONV   = 3'b100,
      A_FINISH = 3'b101
   } asd_adc_state_e;
   typedef enum logic [1:0] {
      F_FETCH  = 2'b00,
      F_SETTLE = 2'b01,
      F_HOLD   = 2'b10
   } asd_ref_state_e;
   // =========================================================
   // converter pin synchronisers
   // =========================================================
   logic                ind_meta;
   logic                ind_sync;
   logic [RESULT_W-1:0] data_meta;
   logic [RESULT_W-1:0] data_sync;
   // two flops each; only the second stage is read by logic
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         ind_meta  <= 1'b0;
         ind_sync  <= 1'b0;
         data_meta <= '0;
         data_sync <= '0;
      end else begin
         ind_meta  <= converter_completion_indicator;
         ind_sync  <= ind_meta;
         data_meta <= adc_data_pins;
         data_sync <= data_meta;
      end
   end
   // =========================================================
   // mode and scan decode
   // =========================================================
   asd_adc_state_e    astate;
   logic [CHAN_W-1:0] chan;
   logic [4:0]        scan_len;
   logic              pass_active;
   asd_mode_e         mode_prev;
   logic              adc_load;
   logic [TMR_W-1:0]  adc_count;
   logic              adc_done;
   wire mode_polled  = (ctrl.mode == MODE_POLLED);
   wire mode_cont    = (ctrl.mode == MODE_CONT_SCAN);
   wire mode_pass    = (ctrl.mode == MODE_ONE_PASS);
   wire mode_changed = (ctrl.mode != mode_prev);
   wire pass_start   = mode_pass && mode_changed;
   // an unloaded length scans all sixteen inputs
   wire [4:0] eff_len = ((scan_len == 5'h00) || (scan_len > SCAN_LEN_MAX))
                        ? SCAN_LEN_MAX : scan_len;
   wire [CHAN_W-1:0] last_chan = CHAN_W'(eff_len - 5'h01);
   wire scan_run     = mode_cont || (mode_pass && pass_active);
   wire chan_diff    = (ctrl.input_select_lines != chan);
   // a settle request or changed select bits in idle; busy states never look at the command
   wire poll_go      = mode_polled && (begin_settle || chan_diff);
   wire seq_go       = (astate == A_IDLE) && !mode_changed &&
                       (poll_go || scan_run);
   wire conv_go      = (astate == A_HOLD) &&
                       (mode_polled ? conversion_start_enable
                                    : (mode_cont || mode_pass));
   wire conv_end     = (astate == A_FINISH) && !ind_sync;
   wire last_done    = conv_end && !mode_polled && (chan == last_chan);
   // one interval timer serves both settle and track phases
   assign adc_load  = seq_go || ((astate == A_SETTLE) && adc_done);
   assign adc_count = seq_go ? (ctrl.short_settle ? TMR_W'(SETTLE_S_CYC)
                                                  : TMR_W'(SETTLE_CYC))
                             : (ctrl.short_settle ? TMR_W'(TRACK_S_CYC)
                                                  : TMR_W'(TRACK_CYC));
   asd_interval_timer #(.W(TMR_W)) u_adc_tmr (
      .core_clk (core_clk),
      .resetn   (resetn),
      .load     (adc_load),
      .count    (adc_count),
      .done     (adc_done)
   );
   // =========================================================
   // conversion sequence
   // =========================================================
   // channel follows the host bits when polled, the scan counter otherwise
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         astate          <= A_IDLE;
         chan            <= '0;
         adc_track       <= 1'b0;
         convert_command <= 1'b0;
         mode_prev       <= MODE_CONT_SCAN;
      end else begin
         mode_prev       <= ctrl.mode;
         convert_command <= 1'b0;
         case (astate)
            A_IDLE: begin
               if (mode_changed) begin
                  chan <= mode_polled ? ctrl.input_select_lines : '0;
               end else if (seq_go) begin
                  if (mode_polled) chan <= ctrl.input_select_lines;
                  astate <= A_SETTLE;
               end
            end
            A_SETTLE: begin
               if (adc_done) begin
                  adc_track <= 1'b1;
                  astate    <= A_TRACK;
               end
            end
            A_TRACK: begin
               if (adc_done) begin
                  adc_track <= 1'b0;                                   // hold mode
                  astate    <= A_HOLD;
               end
            end
            A_HOLD: begin
               if (conv_go) begin
                  convert_command <= 1'b1;
                  astate          <= A_CONV;
               end
            end
            A_CONV: begin
               if (ind_sync) begin                             // converter has begun
                  astate <= A_FINISH;
               end
            end
            A_FINISH: begin
               if (conv_end) begin
                  astate <= A_IDLE;
                  if (!mode_polled) begin
                     chan <= (chan == last_chan) ? '0 : chan + CHAN_W'(1);
                  end
               end
            end
            default: astate <= A_IDLE;
         endcase
      end
   end
   assign input_select_pins = chan;
   // =========================================================
   // status flags (a set always wins over a clear)
   // =========================================================
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         status      <= '0;
         pass_active <= 1'b0;
         scan_len    <= SCAN_LEN_RST;
      end else begin
         if (scan_len_load) scan_len <= scan_len_value;
         if (seq_go) begin
            status.settle_busy <= 1'b1;
         end else if ((astate == A_TRACK) && adc_done) begin
            status.settle_busy <= 1'b0;
         end
         if (conv_go) begin
            status.conversion_busy_flag <= 1'b1;
         end else if (conv_end || result_read) begin
            status.conversion_busy_flag <= 1'b0;
         end
         if (conv_end && mode_polled) begin
            status.fresh_result <= 1'b1;
         end else if (result_read) begin
            status.fresh_result <= 1'b0;
         end
         if (last_done && mode_pass) begin
            status.scan_finished_flag <= 1'b1;
            pass_active               <= 1'b0;
         end else if (pass_start) begin
            status.scan_finished_flag <= 1'b0;
            pass_active               <= 1'b1;
         end
      end
   end
   // =========================================================
   // result storage
   // =========================================================
   logic [RESULT_W-1:0] scan_mem [NUM_IN];
   // polled results go to the result register, scan results per channel
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         conversion_result_register <= '0;
         scan_rd_data               <= '0;
      end else begin
         if (conv_end && mode_polled) begin
            conversion_result_register <= data_sync;
         end
         scan_rd_data <= scan_mem[scan_rd_index];
      end
   end
   // scan storage needs no reset; it is written before it means anything
   always_ff @(posedge core_clk) begin
      if (conv_end && !mode_polled) begin
         scan_mem[chan] <= data_sync;
      end
   end
   // =========================================================
   // output word memory and arbitration
   // =========================================================
   logic [WORD_W-1:0] out_mem [NUM_OUT];
   asd_ref_state_e    fstate;
   logic [CHAN_W-1:0] rch;
   logic              ref_load;
   logic [TMR_W-1:0]  ref_count;
   logic              ref_done;
   // host wins the port; the refresh fetch waits for as long as the host reads or writes
   wire host_busy = host_mem.wr || host_mem.rd;
   wire ref_grant = (fstate == F_FETCH) && !host_busy;
   always_ff @(posedge core_clk) begin
      if (host_mem.wr) begin
         out_mem[host_mem.addr] <= host_mem.wdata;
      end
   end
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         host_mem_rdata <= '0;
      end else if (host_mem.rd && !host_mem.wr) begin
         host_mem_rdata <= out_mem[host_mem.addr];
      end
   end
   // =========================================================
   // output refresh sequence
   // =========================================================
   assign ref_load  = ref_grant || ((fstate == F_SETTLE) && ref_done);
   assign ref_count = ref_grant ? TMR_W'(DAC_SET_CYC)
                                : (ctrl.fast_refresh ? TMR_W'(HOLD_F_CYC)
                                                     : TMR_W'(HOLD_N_CYC));
   asd_interval_timer #(.W(TMR_W)) u_ref_tmr (
      .core_clk (core_clk),
      .resetn   (resetn),
      .load     (ref_load),
      .count    (ref_count),
      .done     (ref_done)
   );
   // fetch, let the DAC settle, then hold the distributor switch on
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         fstate       <= F_FETCH;
         rch          <= '0;
         dac_data     <= '0;
         dac_select   <= '0;
         demux_enable <= 1'b0;
      end else begin
         case (fstate)
            F_FETCH: begin
               if (ref_grant) begin
                  dac_data   <= out_mem[rch][RESULT_W-1:0];
                  dac_select <= rch;
                  fstate     <= F_SETTLE;
               end
            end
            F_SETTLE: begin
               if (ref_done) begin
                  demux_enable <= 1'b1;
                  fstate       <= F_HOLD;
               end
            end
            F_HOLD: begin
               if (ref_done) begin
                  demux_enable <= 1'b0;
                  rch          <= rch + CHAN_W'(1);
                  fstate       <= F_FETCH;
               end
            end
            default: fstate <= F_FETCH;
         endcase
      end
   end
endmodule

// file: verilog/asd_pkg.sv
// asd_pkg: constants, modes and carriers for the converter sequencer and
// the output refresh logic.
// assumes a single 20 MHz core clock; every time figure below is in ns or cycles.
package asd_pkg;

   // =========================================================
   // clock and timing
   // =========================================================
   localparam int CLK_MHZ          = 20;
   localparam int TMR_W            = 16;
   // one output slot is one sixteenth of the whole refresh cycle
   localparam int REFRESH_NORM_NS  = 1_700_000;
   localparam int REFRESH_FAST_NS  = 400_000;
   localparam int DEMUX_HOLD_NS    = 100_000;
   localparam int NUM_OUT          = 16;
   localparam int SLOT_NORM_CYC    = (REFRESH_NORM_NS * CLK_MHZ / 1000) / NUM_OUT;
   localparam int SLOT_FAST_CYC    = (REFRESH_FAST_NS * CLK_MHZ / 1000) / NUM_OUT;
   // fixed cycles spent per slot outside the two timed phases
   localparam int SLOT_OVERHEAD    = 3;

   // =========================================================
   // widths and reset values
   // =========================================================
   localparam int RESULT_W         = 12;
   localparam int WORD_W           = 16;
   localparam int CHAN_W           = 4;
   localparam int NUM_IN           = 16;
   localparam logic [4:0] SCAN_LEN_RST = 5'h00;  // zero means not loaded
   localparam logic [4:0] SCAN_LEN_MAX = 5'h10;

   // =========================================================
   // modes
   // =========================================================
   typedef enum logic [1:0] {
      MODE_CONT_SCAN = 2'b00,
      MODE_POLLED    = 2'b01,
      MODE_ONE_PASS  = 2'b10,
      MODE_UNUSED    = 2'b11
   } asd_mode_e;

   // =========================================================
   // carriers
   // =========================================================
   typedef struct packed {
      asd_mode_e         mode;
      logic              short_settle;
      logic              fast_refresh;
      logic [CHAN_W-1:0] input_select_lines;
   } asd_ctrl_s;

   typedef struct packed {
      logic settle_busy;
      logic conversion_busy_flag;
      logic fresh_result;
      logic scan_finished_flag;
   } asd_status_s;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [CHAN_W-1:0] addr;
      logic [WORD_W-1:0] wdata;
   } asd_mem_req_s;

endpackage

// file: verilog/asd_interval_timer.sv
// asd_interval_timer: loadable down counter giving a one-cycle done pulse.
// assumes load values of at least one cycle, same clock as the user.
`timescale 1ns/10ps
module asd_interval_timer
   import asd_pkg::*;
#(
   parameter int W = TMR_W
) (
   input  wire logic         core_clk,
   input  wire logic         resetn,
   input  wire logic         load,
   input  wire logic [W-1:0] count,
   output logic              done
);

   logic [W-1:0] remain;
   logic         running;

   // =========================================================
   // countdown
   // =========================================================
   // a new load restarts the interval, even while one is running
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         remain  <= '0;
         running <= 1'b0;
         done    <= 1'b0;
      end else if (load) begin
         remain  <= count;
         running <= 1'b1;
         done    <= 1'b0;
      end else begin
         done <= running && (remain <= W'(1));
         if (running && (remain <= W'(1))) begin
            running <= 1'b0;
         end
         if (running) begin
            remain <= remain - W'(1);
         end
      end
   end

endmodule

// file: testbench/asd_seq_chk.sv
// asd_seq_chk: port-level assertions for the converter sequencer.
// assumes it is bound onto asd_sequencer; one core_clk domain.
`timescale 1ns/10ps
module asd_seq_chk
   import asd_pkg::*;
(
   input wire logic              core_clk,
   input wire logic              resetn,
   input wire asd_ctrl_s         ctrl,
   input wire logic              result_read,
   input wire asd_status_s       status,
   input wire logic [CHAN_W-1:0] input_select_pins,
   input wire logic              adc_track,
   input wire logic              convert_command,
   input wire logic [CHAN_W-1:0] dac_select,
   input wire logic              demux_enable
);
   // =========================================================
   // sequencer and refresh properties
   // =========================================================
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   reset_clear_a: assert property ($rose(resetn) |-> status == '0 && !demux_enable)
      else $error("flags not clear after reset");
   track_in_settle_a: assert property (adc_track |-> status.settle_busy)
      else $error("tracking outside settle busy");
   settle_end_a: assert property ($fell(adc_track) |-> $fell(status.settle_busy))
      else $error("settle busy not ending with tracking");
   cmd_pulse_a: assert property (convert_command |=> !convert_command)
      else $error("convert command longer than one cycle");
   cmd_in_hold_a: assert property (convert_command |-> !status.settle_busy && !adc_track)
      else $error("convert command before hold");
   auto_convert_a: assert property ($fell(adc_track) && $stable(ctrl.mode) &&
      (ctrl.mode == MODE_CONT_SCAN || ctrl.mode == MODE_ONE_PASS) |-> ##[0:2] convert_command)
      else $error("no automatic convert command");
   busy_on_cmd_a: assert property (convert_command && ctrl.mode == MODE_POLLED
      |-> ##[0:1] status.conversion_busy_flag)
      else $error("busy flag not set by conversion start");
   read_clear_a: assert property (result_read |=> !status.fresh_result
      && !status.conversion_busy_flag)
      else $error("result read left flags set");
   input_sel_a: assert property (adc_track && ctrl.mode == MODE_POLLED
      |-> input_select_pins == ctrl.input_select_lines)
      else $error("input select does not follow control bits");
   demux_hold_a: assert property ($rose(demux_enable) |-> demux_enable[*8])
      else $error("demux enable too short");
   demux_chan_a: assert property (demux_enable |=> !demux_enable || $stable(dac_select))
      else $error("output select moved while demux on");
endmodule

bind asd_sequencer asd_seq_chk chk (.core_clk(core_clk), .resetn(resetn), .ctrl(ctrl),
   .result_read(result_read), .status(status), .input_select_pins(input_select_pins),
   .adc_track(adc_track), .convert_command(convert_command), .dac_select(dac_select),
   .demux_enable(demux_enable));

// file: testbench/asd_adc_model.sv
// asd_adc_model: behavioural converter and input mux at the far side.
// assumes convert_command is a one-cycle pulse on core_clk.
`timescale 1ns/10ps
module asd_adc_model
   import asd_pkg::*;
#(
   parameter int BUSY_CYC = 8
) (
   input  wire logic              core_clk,
   input  wire logic [CHAN_W-1:0] input_select_pins,
   input  wire logic              convert_command,
   output logic                   converter_completion_indicator,
   output logic [RESULT_W-1:0]    adc_data_pins
);
   logic [7:0]        cnt = 8'h00;
   logic [CHAN_W-1:0] chan = 4'h0;
   // =========================================================
   // conversion timing
   // =========================================================
   // count from the command, zero is idle; channel held from the command
   always @(posedge core_clk) begin
      if (convert_command) begin
         cnt <= 8'h01;
         chan <= input_select_pins;
      end else if (cnt != 8'h00) begin
         cnt <= (cnt == 8'(BUSY_CYC + 10)) ? 8'h00 : cnt + 8'h01;
      end
   end
   // indicator high only while converting
   assign converter_completion_indicator = (cnt >= 8'h03) && (cnt < 8'(BUSY_CYC + 3));
   // word valid past the fall for the sync delay, then the released lines show the inverse
   assign adc_data_pins = ((cnt >= 8'h02) && (cnt < 8'(BUSY_CYC + 9))) ?
                          {8'hA5, chan} : ~{8'hA5, chan};
endmodule

// file: testbench/tb_top.sv
// tb_top: directed bench for the converter sequencer and output refresh.
// assumes asd_pkg, the converter model and the bound checker are compiled first.
`timescale 1ns/10ps
module tb_top;
   import asd_pkg::*;
   logic                core_clk = 1'b0;
   logic                resetn = 1'b0;
   asd_ctrl_s           ctrl = '{MODE_POLLED, 1'b0, 1'b0, 4'h0};
   logic                begin_settle = 1'b0;
   logic                start_en = 1'b0;
   logic                result_read = 1'b0;
   logic                scan_len_load = 1'b0;
   logic [4:0]          scan_len_value = 5'h00;
   logic [CHAN_W-1:0]   scan_rd_index = 4'h0;
   asd_mem_req_s        host_mem = '0;
   asd_status_s         status;
   logic [RESULT_W-1:0] result_q, scan_rd_data, adc_data_pins, dac_data;
   logic [WORD_W-1:0]   host_mem_rdata;
   logic [CHAN_W-1:0]   input_select_pins, dac_select;
   logic                adc_track, convert_command, conv_ind, demux_enable;
   logic [WORD_W-1:0]   exp_mem [NUM_OUT];
   int                  n_errors = 0, check_count = 0, cyc = 0, n_cmd = 0;
   int                  len_a, len_b, len_c, mx, c0;

   // short settle and track values keep the run brief
   asd_sequencer #(.SETTLE_NS(500), .SETTLE_SHORT_NS(200), .TRACK_NS(300), .TRACK_SHORT_NS(150)
   ) uut (.core_clk(core_clk), .resetn(resetn), .ctrl(ctrl), .begin_settle(begin_settle),
      .conversion_start_enable(start_en), .result_read(result_read),
      .scan_len_load(scan_len_load), .scan_len_value(scan_len_value), .status(status),
      .conversion_result_register(result_q), .scan_rd_index(scan_rd_index),
      .scan_rd_data(scan_rd_data), .host_mem(host_mem), .host_mem_rdata(host_mem_rdata),
      .input_select_pins(input_select_pins), .adc_track(adc_track),
      .convert_command(convert_command), .converter_completion_indicator(conv_ind),
      .adc_data_pins(adc_data_pins), .dac_data(dac_data), .dac_select(dac_select),
      .demux_enable(demux_enable));
   asd_adc_model adc (.core_clk(core_clk), .input_select_pins(input_select_pins),
      .convert_command(convert_command), .converter_completion_indicator(conv_ind),
      .adc_data_pins(adc_data_pins));

   // =========================================================
   // clock, cycle count, hang guard
   // =========================================================
   always #25 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (convert_command === 1'b1) n_cmd <= n_cmd + 1;
      if (cyc == 40000) begin
         n_errors++;
         print_verdict();
      end
   end

   task automatic print_verdict;
      if (n_errors == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         n_errors++;
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // one-cycle host strobe: 0 settle request, 1 start enable, 2 result read, 3 length load
   task automatic pulse(input int which);
      {scan_len_load, result_read, start_en, begin_settle} <= 4'(1 << which);
      @(posedge core_clk);
      {scan_len_load, result_read, start_en, begin_settle} <= 4'h0;
   endtask

   // one host-owned conversion; len returns the settle-busy length in cycles
   task automatic polled(input logic [3:0] ch, input logic sh, bs, dup, output int len);
      @(posedge core_clk);
      ctrl.input_select_lines <= ch;
      ctrl.short_settle <= sh;
      if (bs) pulse(0);
      len = 0;
      for (int i = 0; i < 120; i++) begin
         @(posedge core_clk);
         if (status.settle_busy === 1'b1) len++;
         else if (len > 0) break;
         if (dup && len == 3) begin_settle <= 1'b1;
         if (len == 4) begin_settle <= 1'b0;
      end
      c0 = n_cmd;
      tick(6);
      check(n_cmd - c0, 0);
      pulse(1);
      tick(2);
      check(status.conversion_busy_flag, 1'b1);
      for (int i = 0; i < 60 && status.fresh_result !== 1'b1; i++) @(posedge core_clk);
      check({status.fresh_result, status.conversion_busy_flag}, 2'b10);
      check(result_q, {8'hA5, ch});
      check(n_cmd - c0, 1);
      pulse(2);
      tick(2);
      check({status.fresh_result, status.conversion_busy_flag}, 2'b00);
   endtask

   // watch n+1 demux pulses: stored word, next channel, one slot apart
   task automatic refresh_run(input int n, input int slot, input int hmin);
      int         t0, hi, k;
      logic [3:0] sel;
      logic       d_q;
      k = 0;
      t0 = 0;
      hi = 0;
      d_q = 1'b1;
      for (int i = 0; i < 25000 && k <= n; i++) begin
         @(posedge core_clk);
         if (demux_enable === 1'b1) hi++;
         if (demux_enable === 1'b1 && d_q === 1'b0) begin
            if (k > 0) check(cyc - t0, slot);
            if (k > 0) check(dac_select, 4'(sel + 4'h1));
            check(dac_data, exp_mem[dac_select][11:0]);
            sel = dac_select;
            t0 = cyc;
            hi = 1;
            k++;
         end
         if (demux_enable === 1'b0 && d_q === 1'b1 && k > 0) check(hi >= hmin, 1'b1);
         d_q = demux_enable;
      end
      check(k, n + 1);
   endtask

   // =========================================================
   // main sequence
   // =========================================================
   initial begin
      tick(12);
      resetn <= 1'b1;
      @(posedge core_clk);
      check({status, demux_enable, dac_select, convert_command}, 0);
      // output words written out of order, one read back
      for (int i = NUM_OUT - 1; i >= 0; i--) begin
         exp_mem[i] = 16'hC000 | (16'(i) * 16'h0111);
         host_mem <= '{1'b1, 1'b0, 4'(i), exp_mem[i]};
         @(posedge core_clk);
      end
      host_mem <= '{1'b0, 1'b1, 4'h7, 16'h0000};
      @(posedge core_clk);
      host_mem <= '0;
      @(posedge core_clk);
      check(host_mem_rdata, exp_mem[7]);
      polled(4'h5, 1'b0, 1'b0, 1'b0, len_a);
      polled(4'h5, 1'b0, 1'b1, 1'b1, len_b);
      polled(4'h9, 1'b1, 1'b1, 1'b0, len_c);
      check(len_b, len_a);
      check(len_a >= 16 && len_a <= 18, 1'b1);
      check(len_c >= 7 && len_c <= 9, 1'b1);
      // continuous scan with no length loaded covers all sixteen inputs
      ctrl.mode <= MODE_CONT_SCAN;
      mx = 0;
      for (int i = 0; i < 1500; i++) begin
         @(posedge core_clk);
         if (convert_command === 1'b1 && int'(input_select_pins) > mx) mx = input_select_pins;
      end
      check(mx, 15);
      ctrl.mode <= MODE_UNUSED;
      tick(100);
      mx = 0;
      for (int i = 0; i < 50; i++) begin
         @(posedge core_clk);
         if (status.settle_busy !== 1'b0) mx++;
      end
      check(mx, 0);
      scan_len_value <= 5'h03;
      pulse(3);
      ctrl.mode <= MODE_ONE_PASS;
      c0 = n_cmd;
      for (int i = 0; i < 400 && status.scan_finished_flag !== 1'b1; i++) @(posedge core_clk);
      check(status.scan_finished_flag, 1'b1);
      tick(100);
      check(n_cmd - c0, 3);
      for (int i = 0; i < 3; i++) begin
         scan_rd_index <= 4'(i);
         tick(2);
         check(scan_rd_data, {8'hA5, 4'(i)});
      end
      refresh_run(2, SLOT_NORM_CYC, 1900);
      ctrl.fast_refresh <= 1'b1;
      tick(2200);
      refresh_run(16, SLOT_FAST_CYC, 400);
      print_verdict();
   end
endmodule
